// File: hdl/lsd_defs.vh
// constants for the logical shift datapath
`ifndef LSD_DEFS_VH
`define LSD_DEFS_VH

// operand and count widths
`define LSD_W            32
`define LSD_REG_CNT_W    11
`define LSD_IMM_CNT_W    6
`define LSD_OPERAND_BITS 7'h20

// low fourteen-bit opcode field positions
`define LSD_OPC_HI       13
`define LSD_SEL_HI       2
`define LSD_IMM_CNT_LSB  3
`define LSD_SRC_LSB      8

// immediate forms: upper eighteen bits are fixed
`define LSD_IMM_UPPER    18'h00002
`define LSD_IMM_LSL_TAG  5'h0b
`define LSD_IMM_LSR_TAG  5'h0a

// data-bus-move forms, patterns over bits 13..0
`define LSD_REG_MASK     14'h38f8
`define LSD_REG_LSL_VAL  14'h3020
`define LSD_REG_LSR_VAL  14'h3028
`define LSD_ONE_MASK     14'h3f38
`define LSD_ONE_LSR_VAL  14'h2018
`define LSD_ONE_LSL_VAL  14'h2118
`define LSD_FIX_NOP_VAL  14'h2000
`define LSD_FLT_NOP_VAL  14'h2004

// condition code bit positions
`define LSD_CC_C         0
`define LSD_CC_V         1
`define LSD_CC_Z         2
`define LSD_CC_N         3

// timing: base oscillator cycles and words
`define LSD_BASE_CYCLES  4'h2
`define LSD_BASE_WORDS   4'h1

// reset values
`define LSD_CCR_RST      8'h00

`endif

// File: hdl/lsd_shift_datapath.v
// logical shift datapath with instruction decoding and data register file
`timescale 1ns/1ps
`include "lsd_defs.vh"

//
// Contract
// - right shift by one moves lsb into carry, zero enters bit 31.
// - count from 11 lsbs of source high part, or 6-bit immediate.
// - carry is last bit shifted out, cleared for zero count.
// - counts above 32 give zero result and cleared carry.
// - right shift by n fills n top bits with zero; result to low part.
// - immediate counts reach 63 in either direction.
// - z from zero result, n from bit 31, v always cleared.
// - other condition bits, exception status and sticky flags untouched by shifts.
// - operands and results are 32-bit integers.
// - immediate left shift encoding, tag 011, six-bit count, destination.
// - immediate right shift encoding same, tag 010.
// - register-count left shift low bits 11 0sss 0010 0ddd.
// - register-count right shift as left, lowest nibble 1ddd.
// - single-bit right shift low bits 10 0000 uu01 1ddd.
// - destination picks low part, source picks high part, registers 0-7.
// - immediate forms take 2 cycles, 1 word; move forms add move costs.
// - plain move is integer or floating no-op carrying only moves.
// - fixed-point no-op decoded from low bits 10 and twelve zeros.
// - plain move leaves condition, exception status and sticky flags alone.
// - alu operation and up to two bus transfers share one cycle.
// - moves are reg-reg, reg-mem or mem-reg, checked by move unit.
// - left shift by one moves msb into carry, zero enters bit 0.
// - left shift by n fills n low bits with zero.
module lsd_shift_datapath (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // decoded instruction from program controller
  input  wire        instr_valid,
  input  wire [31:0] instr_word,
  input  wire [3:0]  extra_move_cost,
  input  wire [3:0]  extra_move_words,
  // parallel move unit write port, same cycle as alu op
  input  wire        move_x_we,
  input  wire [3:0]  move_x_sel,
  input  wire [31:0] move_x_data,
  input  wire        move_y_we,
  input  wire [3:0]  move_y_sel,
  input  wire [31:0] move_y_data,
  // condition code byte as held by status logic
  input  wire [7:0]  condition_code_in,
  // results
  output reg  [7:0]  condition_code_bits,
  output reg         cc_update,
  output reg         shift_op_done,
  output reg         nop_done,
  output reg         float_nop,
  output reg         illegal_op,
  output reg  [3:0]  op_cycles,
  output reg  [3:0]  op_words,
  output reg  [31:0] result_low,
  output reg  [2:0]  result_sel,
  // register file peek for the move unit and status
  input  wire [2:0]  peek_sel,
  output reg  [31:0] peek_low,
  output reg  [31:0] peek_high,
  output wire        exception_status_hold,
  output wire        sticky_flags_hold
);

  // operation classes; OP_NONE marks a refused word that writes nothing
  // binary codes, one class per decoded form, except that both no-op forms share OP_NOP
  localparam OP_NONE    = 3'h0;
  localparam OP_LSL_IMM = 3'h1;
  localparam OP_LSR_IMM = 3'h2;
  localparam OP_LSL_REG = 3'h3;
  localparam OP_LSR_REG = 3'h4;
  localparam OP_LSR_ONE = 3'h5;
  localparam OP_LSL_ONE = 3'h6;
  localparam OP_NOP     = 3'h7;

  // data registers: low and high parts of d0..d7
  reg [31:0] data_reg_low_part  [0:7];
  reg [31:0] data_reg_high_part [0:7];

  // decoder, used for classification and timing
  // the immediate forms are tried first: their upper word is fixed, while the
  // move forms leave bits 31..14 to the parallel move unit and could alias
  function [2:0] lsd_decode;
    input [31:0] w;
    begin
      lsd_decode = OP_NONE;
      if (w[31:14] == `LSD_IMM_UPPER && w[13:9] == `LSD_IMM_LSL_TAG)
        lsd_decode = OP_LSL_IMM;
      else if (w[31:14] == `LSD_IMM_UPPER && w[13:9] == `LSD_IMM_LSR_TAG)
        lsd_decode = OP_LSR_IMM;
      else if ((w[13:0] & `LSD_REG_MASK) == `LSD_REG_LSL_VAL)
        lsd_decode = OP_LSL_REG;
      else if ((w[13:0] & `LSD_REG_MASK) == `LSD_REG_LSR_VAL)
        lsd_decode = OP_LSR_REG;
      else if ((w[13:0] & `LSD_ONE_MASK) == `LSD_ONE_LSR_VAL)
        lsd_decode = OP_LSR_ONE;
      else if ((w[13:0] & `LSD_ONE_MASK) == `LSD_ONE_LSL_VAL)
        lsd_decode = OP_LSL_ONE;
      else if (w[13:0] == `LSD_FIX_NOP_VAL)
        lsd_decode = OP_NOP;
      // floating no-op shares the class, bit 2 tells them apart
      else if (w[13:0] == `LSD_FLT_NOP_VAL)
        lsd_decode = OP_NOP;
    end
  endfunction

  // decode wires; every class comes from the one decoder call so that
  // the count, the direction and the answer pulses can never disagree
  // the selectors are read for every word, even when they are meaningless
  wire [2:0]  op_cls   = lsd_decode(instr_word);
  wire        is_imm   = (op_cls == OP_LSL_IMM) || (op_cls == OP_LSR_IMM);
  wire        is_left  = (op_cls == OP_LSL_IMM) || (op_cls == OP_LSL_REG) || (op_cls == OP_LSL_ONE);
  wire        is_shift = (op_cls != OP_NONE) && (op_cls != OP_NOP);
  wire [2:0]  dst_sel  = instr_word[`LSD_SEL_HI:0];
  wire [2:0]  src_sel  = instr_word[`LSD_SRC_LSB+2:`LSD_SRC_LSB];
  wire [31:0] operand  = data_reg_low_part[dst_sel];
  wire [31:0] src_high = data_reg_high_part[src_sel];

  // single-bit forms are a count of one and share the multi-bit shifter,
  // which keeps carry and flag handling in one place for all shift forms
  // shift count selection, widened to 11 bits
  reg  [10:0] shift_cnt;
  always @* begin
    case (op_cls)
      OP_LSL_IMM, OP_LSR_IMM: shift_cnt = {5'h00, instr_word[`LSD_IMM_CNT_LSB+5:`LSD_IMM_CNT_LSB]};
      OP_LSL_REG, OP_LSR_REG: shift_cnt = src_high[`LSD_REG_CNT_W-1:0];
      OP_LSR_ONE, OP_LSL_ONE: shift_cnt = 11'h001;
      default:                shift_cnt = 11'h000;
    endcase
  end

  // shifter on a 33-bit extension so the last bit out lands in the guard bit
  // a count of exactly 32 still reaches the guard bit: the result is zero and
  // carry takes the far-end bit; only counts above 32 force carry low as well
  // the eleven-bit count is compared whole, so high bits never wrap into n6
  reg [31:0] shift_res;
  reg        shift_c;
  reg [32:0] ext;
  reg [5:0]  n6;
  always @* begin
    ext       = 33'h000000000;
    n6        = shift_cnt[5:0];
    shift_res = 32'h00000000;
    shift_c   = 1'b0;
    if (shift_cnt == 11'h000) begin
      shift_res = operand;
      shift_c   = 1'b0;
    end else if (shift_cnt > {4'h0, `LSD_OPERAND_BITS}) begin
      shift_res = 32'h00000000;
      shift_c   = 1'b0;
    end else if (is_left) begin
      // msb to carry on single shift
      ext       = {1'b0, operand} << n6;
      shift_res = ext[31:0];
      shift_c   = ext[32];
    end else begin
      // lsb to carry, zero into bit 31
      ext       = {operand, 1'b0} >> n6;
      shift_res = ext[32:1];
      shift_c   = ext[0];
    end
  end

  // flags from the 32-bit integer result
  // v has no meaning for a logical shift and is always cleared
  reg [7:0] cc_nxt;
  always @* begin
    cc_nxt = condition_code_in;
    cc_nxt[`LSD_CC_C] = shift_c;
    cc_nxt[`LSD_CC_V] = 1'b0;
    cc_nxt[`LSD_CC_Z] = (shift_res == 32'h00000000);
    cc_nxt[`LSD_CC_N] = shift_res[31];
  end

  // register file writes; alu result and move writes land in one cycle
  // duplicate destinations are illegal in software, the move port wins here
  // the y port is applied last, so it wins over x on a shared destination;
  // a refused word never writes, since only shift classes enable the alu port
  integer i;
  always @(posedge clk) begin
    if (sys_rst) begin
      for (i = 0; i < 8; i = i + 1) begin
        data_reg_low_part[i]  <= 32'h00000000;
        data_reg_high_part[i] <= 32'h00000000;
      end
    end else begin
      if (instr_valid && is_shift)
        data_reg_low_part[dst_sel] <= shift_res;
      // two bus transfers alongside the alu op
      // direction checks belong to the move unit
      if (move_x_we) begin
        if (move_x_sel[3])
          data_reg_high_part[move_x_sel[2:0]] <= move_x_data;
        else
          data_reg_low_part[move_x_sel[2:0]] <= move_x_data;
      end
      if (move_y_we) begin
        if (move_y_sel[3])
          data_reg_high_part[move_y_sel[2:0]] <= move_y_data;
        else
          data_reg_low_part[move_y_sel[2:0]] <= move_y_data;
      end
    end
  end

  // one-cycle answer pulses, one per accepted word
  always @(posedge clk) begin
    if (sys_rst) begin
      cc_update     <= 1'b0;
      shift_op_done <= 1'b0;
      nop_done      <= 1'b0;
      float_nop     <= 1'b0;
      illegal_op    <= 1'b0;
    end else begin
      cc_update     <= instr_valid && is_shift;
      shift_op_done <= instr_valid && is_shift;
      nop_done      <= instr_valid && (op_cls == OP_NOP);
      float_nop     <= instr_valid && (op_cls == OP_NOP) && instr_word[2];
      illegal_op    <= instr_valid && (op_cls == OP_NONE);
    end
  end

  // held results; only a shift moves them, so a no-op or a refused word
  // leaves the condition byte exactly as the last shift left it
  always @(posedge clk) begin
    if (sys_rst) begin
      condition_code_bits <= `LSD_CCR_RST;
      result_low          <= 32'h00000000;
      result_sel          <= 3'h0;
    end else begin
      if (instr_valid && is_shift) begin
        condition_code_bits <= cc_nxt;
        result_low          <= shift_res;
        result_sel          <= dst_sel;
      end
    end
  end

  // cost sums are one bit wider, then cut to the four-bit outputs;
  // a move cost above 13 cycles or 14 words wraps, the controller keeps it small
  wire [4:0]  cyc_sum  = {1'b0, `LSD_BASE_CYCLES} + {1'b0, extra_move_cost};
  wire [4:0]  wrd_sum  = {1'b0, `LSD_BASE_WORDS} + {1'b0, extra_move_words};

  // cost of the last accepted word, held between words
  always @(posedge clk) begin
    if (sys_rst) begin
      op_cycles <= 4'h0;
      op_words  <= 4'h0;
    end else if (instr_valid) begin
      if (is_imm) begin
        op_cycles <= `LSD_BASE_CYCLES;
        op_words  <= `LSD_BASE_WORDS;
      end else begin
        op_cycles <= cyc_sum[3:0];
        op_words  <= wrd_sum[3:0];
      end
    end
  end

  // register peek, registered for the move unit
  // the peek lags one cycle, so a write shows two edges after its word
  always @(posedge clk) begin
    if (sys_rst) begin
      peek_low  <= 32'h00000000;
      peek_high <= 32'h00000000;
    end else begin
      peek_low  <= data_reg_low_part[peek_sel];
      peek_high <= data_reg_high_part[peek_sel];
    end
  end

  // the status logic owns these bits; the holds tell it a shift never changes them
  // exception status and sticky flags are never written here
  assign exception_status_hold = 1'b1;
  assign sticky_flags_hold     = 1'b1;

endmodule

// File: sim/lsd_sva.sv
// port assertions for the logical shift datapath
`timescale 1ns/1ps
module lsd_sva (
  // clock and reset
  input wire        clk,
  input wire        sys_rst,
  // instruction
  input wire        instr_valid,
  input wire [31:0] instr_word,
  input wire [7:0]  condition_code_in,
  // results
  input wire [7:0]  condition_code_bits,
  input wire        cc_update,
  input wire        shift_op_done,
  input wire        nop_done,
  input wire        float_nop,
  input wire        illegal_op,
  input wire [3:0]  op_cycles,
  input wire [3:0]  op_words,
  input wire [31:0] result_low
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // flags, pass-through bits and answers tied to their causes
  property p_flags; cc_update |-> condition_code_bits[3:1] == {result_low[31], result_low == 32'h0, 1'b0}; endproperty
  a_flags: assert property (p_flags) else $error("flags off result");
  property p_pass; cc_update |-> condition_code_bits[7:4] == $past(condition_code_in[7:4]); endproperty
  a_pass: assert property (p_pass) else $error("upper cc bits changed");
  property p_hold; !cc_update |-> $stable(condition_code_bits); endproperty
  a_hold: assert property (p_hold) else $error("cc moved without shift");
  property p_resp; instr_valid |=> shift_op_done || nop_done || illegal_op; endproperty
  a_resp: assert property (p_resp) else $error("no answer");
  property p_one; $onehot0({shift_op_done, nop_done, illegal_op}); endproperty
  a_one: assert property (p_one) else $error("two answers");
  property p_fltn; nop_done |-> float_nop == $past(instr_word[13:0] == 14'h2004); endproperty
  a_fltn: assert property (p_fltn) else $error("no-op kind wrong");
  property p_imm; instr_valid && instr_word[31:10] == 22'h25 |=> shift_op_done && {op_cycles, op_words} == 8'h21; endproperty
  a_imm: assert property (p_imm) else $error("immediate cost wrong");
  property p_big; instr_valid && instr_word[31:10] == 22'h25 && instr_word[8:3] > 6'h20
    |=> result_low == 32'h0 && !condition_code_bits[0]; endproperty
  a_big: assert property (p_big) else $error("long shift not zero");
  property p_zc; instr_valid && instr_word[31:10] == 22'h25 && instr_word[8:3] == 6'h00 |=> !condition_code_bits[0]; endproperty
  a_zc: assert property (p_zc) else $error("carry set on zero count");
  property p_fix; instr_valid && instr_word[13:0] == 14'h2000 |=> nop_done && !float_nop; endproperty
  a_fix: assert property (p_fix) else $error("fixed no-op not taken");
  property p_onr; instr_valid && (instr_word[13:0] & 14'h3f38) == 14'h2018 |=> shift_op_done && cc_update; endproperty
  a_onr: assert property (p_onr) else $error("one-bit right not taken");
  c_carry: cover property (shift_op_done && condition_code_bits[0]);
  c_fnop: cover property (float_nop);
  c_ill: cover property (illegal_op);
endmodule
bind lsd_shift_datapath lsd_sva lsd_sva_i (.*);

// File: sim/lsd_ctl_model.sv
// program controller model issuing instruction words
`timescale 1ns/1ps
module lsd_ctl_model (
  // clock
  input  wire        clk,
  // instruction out
  output reg         instr_valid,
  output reg  [31:0] instr_word,
  output reg  [3:0]  extra_move_cost,
  output reg  [3:0]  extra_move_words
);
  initial begin
    instr_valid = 1'b0;
    instr_word = 32'h0;
    extra_move_cost = 4'h3;
    extra_move_words = 4'h1;
  end
  // one word per call; released word is inverted so stale data never matches
  task issue(input [31:0] w);
    begin
      @(negedge clk);
      instr_valid = 1'b1;
      instr_word = w;
      @(negedge clk);
      instr_valid = 1'b0;
      instr_word = ~w;
    end
  endtask
endmodule

// File: sim/tb.sv
// self-checking bench for the logical shift datapath
`timescale 1ns/1ps
module tb;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         move_x_we = 1'b0;
  reg         move_y_we = 1'b0;
  reg  [3:0]  move_x_sel = 4'h0;
  reg  [3:0]  move_y_sel = 4'h8;
  reg  [31:0] move_x_data = 32'h0;
  reg  [31:0] move_y_data = 32'h0;
  reg  [7:0]  condition_code_in = 8'h5a;
  reg  [2:0]  peek_sel = 3'h0;
  wire        instr_valid, cc_update, shift_op_done, nop_done, float_nop, illegal_op;
  wire        exception_status_hold, sticky_flags_hold;
  wire [31:0] instr_word, result_low, peek_low, peek_high;
  wire [3:0]  extra_move_cost, extra_move_words, op_cycles, op_words;
  wire [7:0]  condition_code_bits;
  wire [2:0]  result_sel;
  integer     error_cnt = 0;
  integer     n_checks = 0;
  // 50 ns clock
  always #25 clk = ~clk;
  lsd_ctl_model lsd_ctl_model_i (.*);
  lsd_shift_datapath lsd_shift_datapath_i (.*);
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // low part by x port, high part by y port in the same cycle
  task put(input [2:0] r, input [31:0] lo, input [2:0] s, input [31:0] hi);
    begin
      @(negedge clk);
      move_x_we = 1'b1;
      move_x_sel = {1'b0, r};
      move_x_data = lo;
      move_y_we = 1'b1;
      move_y_sel = {1'b1, s};
      move_y_data = hi;
      @(negedge clk);
      move_x_we = 1'b0;
      move_y_we = 1'b0;
      repeat (2) @(negedge clk);
    end
  endtask
  // bounded wait, the answer is due one edge after the word
  task wait_done;
    integer t;
    begin
      for (t = 0; t < 4 && shift_op_done !== 1'b1 && nop_done !== 1'b1 && illegal_op !== 1'b1; t = t + 1)
        @(negedge clk);
    end
  endtask
  // kinds: 0/1 immediate left/right, 2/3 register count, 4/5 one bit right/left
  task shc(input [2:0] k, input [2:0] r, input [2:0] s, input [31:0] a, input [31:0] h);
    reg [31:0] w, e;
    reg [10:0] n;
    reg        c;
    begin
      put(r, a, s, h);
      n = k > 3'h3 ? 11'h1 : (k < 3'h2 ? {5'h0, h[5:0]} : h[10:0]);
      case (k)
        3'h0, 3'h1: w = {18'h2, 4'h5, ~k[0], h[5:0], r};
        3'h2, 3'h3: w = {18'h181, 3'h6, s, 4'h2, k[0], r};
        default: w = {18'h181, 5'h10, k[0], 4'hd, 1'b1, r};
      endcase
      e = 32'h0;
      c = 1'b0;
      if (n == 11'h0)
        e = a;
      else if (n <= 11'h20 && k[0] == (k > 3'h3)) begin
        e = a << n;
        c = a[32 - n];
      end else if (n <= 11'h20) begin
        e = a >> n;
        c = a[n - 1];
      end
      lsd_ctl_model_i.issue(w);
      wait_done;
      chk({shift_op_done, cc_update}, 2'h3);
      chk(result_low, e);
      chk(condition_code_bits, {condition_code_in[7:4], e[31], e == 32'h0, 1'b0, c});
      chk({result_sel, op_cycles, op_words}, {r, k < 3'h2 ? 8'h21 : 8'h52});
      peek_sel = r;
      repeat (2) @(negedge clk);
      chk(peek_low, e);
      peek_sel = s;
      repeat (2) @(negedge clk);
      chk(peek_high, h);
      chk({exception_status_hold, sticky_flags_hold}, 2'h3);
    end
  endtask
  // no-op or refused word leaves the condition byte alone
  task other(input [31:0] w, input [2:0] f);
    reg [7:0] h;
    begin
      h = condition_code_bits;
      condition_code_in = 8'h3c;
      lsd_ctl_model_i.issue(w);
      wait_done;
      chk({nop_done, float_nop, illegal_op}, f);
      chk(condition_code_bits, h);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // hang guard, far beyond the some 140 cycles needed
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(negedge clk);
    chk(condition_code_bits, 8'h00);
    sys_rst = 1'b0;
    shc(3'h4, 3'h3, 3'h0, 32'h80000001, 32'h0);
    shc(3'h5, 3'h4, 3'h0, 32'h80000001, 32'h0);
    shc(3'h0, 3'h0, 3'h1, 32'hc0000001, 32'h3f);
    shc(3'h1, 3'h7, 3'h1, 32'hf0000000, 32'h4);
    shc(3'h0, 3'h1, 3'h2, 32'h00000003, 32'h1f);
    shc(3'h1, 3'h2, 3'h2, 32'h12345678, 32'h0);
    shc(3'h2, 3'h5, 3'h6, 32'h80000001, 32'h20);
    shc(3'h3, 3'h6, 3'h1, 32'h80000000, 32'h20);
    shc(3'h3, 3'h2, 3'h3, 32'hffffffff, 32'h7ff);
    shc(3'h2, 3'h1, 3'h7, 32'h0f0f0f0f, 32'hfffff804);
    shc(3'h0, 3'h5, 3'h0, 32'h00000001, 32'h21);
    other({18'h181, 14'h2000}, 3'h4);
    other({18'h181, 14'h2004}, 3'h6);
    other(32'hffffffff, 3'h1);
    // a shift and both move ports in one cycle, on distinct destinations
    put(3'h3, 32'h00000010, 3'h0, 32'h0);
    fork
      lsd_ctl_model_i.issue({18'h2, 4'h5, 1'b1, 6'h02, 3'h3});
      begin
        @(negedge clk);
        move_x_we = 1'b1;
        move_x_sel = 4'h6;
        move_x_data = 32'h0000abcd;
        move_y_we = 1'b1;
        move_y_sel = 4'he;
        move_y_data = 32'h00001234;
        @(negedge clk);
        move_x_we = 1'b0;
        move_y_we = 1'b0;
      end
    join
    chk(result_low, 32'h00000040);
    peek_sel = 3'h6;
    repeat (2) @(negedge clk);
    chk(peek_low, 32'h0000abcd);
    chk(peek_high, 32'h00001234);
    peek_sel = 3'h3;
    repeat (2) @(negedge clk);
    chk(peek_low, 32'h00000040);
    tally_and_finish;
  end
endmodule
